// ---- rtl/upt_mem.sv ----
// Purpose: small byte store for the slave-side cell buffer
// Assumes: one write port, one read port, registered read data
// Notes: depth and width are parameters
`timescale 1ns/1ps
`default_nettype none
module upt_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 64
) (
	input wire logic ref_clk, // Clock
	input wire logic wr_en, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] wr_addr, // Write address
	input wire logic [WIDTH-1:0] wr_data, // Write data
	input wire logic [$clog2(DEPTH)-1:0] rd_addr, // Read address
	output logic [WIDTH-1:0] rd_data // Registered read data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_d;

	// Read is combinational, then registered
	always_comb
	begin
		rd_data_d = mem[rd_addr];
	end

	// Storage has no reset; contents are written before read
	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= rd_data_d;
	end
endmodule : upt_mem
`default_nettype wire

// ---- rtl/upt_pkg.sv ----
// Purpose: shared constants and types for the upper port A transmit pins
// Assumes: one clock, synchronous active-high reset
// Notes: pin personalities are chosen by a static mode input
package upt_pkg;
	// ------------------------------------------------------------
	// Cell and addressing constants
	// ------------------------------------------------------------
	localparam int CELL_BYTES = 53;
	localparam int DIRECT_PHYS = 4;
	localparam logic [4:0] NULL_PORT = 5'h1f;
	localparam logic [4:0] MAX_PHY_ADDR = 5'h1e;
	localparam logic [7:0] IDLE_BYTE = 8'h00;
	localparam int FIFO_DEPTH = 64;
	// Pin indices within the upper port A group
	localparam int PIN_TXEN = 0;
	localparam int PIN_CLAV = 1;
	localparam int PIN_SOC = 2;

	// Personality of the shared pins
	typedef enum logic [2:0] {
		MODE_UTOPIA_SLAVE,
		MODE_UTOPIA_DIRECT,
		MODE_UTOPIA_MUX,
		MODE_MII,
		MODE_HDLC_SERIAL,
		MODE_HDLC_NIBBLE
	} upt_mode_t;

	// Three shared pins as output/enable
	typedef struct packed {
		logic [2:0] o;
		logic [2:0] oe_n;
	} upt_pins_t;

	// Byte handed in by the cell or frame source
	typedef struct packed {
		logic valid;
		logic first;
		logic [7:0] data;
	} upt_beat_t;
endpackage : upt_pkg

// ---- rtl/upt_port.sv ----
// Purpose: transmit-side pins of the first fast serial controller
// Assumes: synchronous inputs, static mode during operation
// Notes: slave mode advertises space only when a whole cell fits in the buffer
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Multiplex master polls addresses 0..30; address 31 is the null port.
// - Direct master polls up to four PHYs on separate avail lines.
// - Master drives enable low only while sending cell bytes, idle cells included.
// - Slave shows cell available only with room for a whole cell.
// - Start of cell marks exactly the first byte of each cell.
// - MII transmit error follows the forced error request.
// - HDLC requests with request low; granted once clear comes low.
// - HDLC moves one bit or four bits per transfer.
// - Idle cells fill gaps; every cell is 53 bytes.
module upt_port
	import upt_pkg::*;
#(
	parameter int CELLS = CELL_BYTES,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk, // Clock
	input wire logic reset, // Sync reset, high
	input wire upt_mode_t mode, // Pin personality
	input wire logic [2:0] pin_i, // Pin levels seen
	output upt_pins_t pins, // Pin drive and enables
	output logic [7:0] txd, // Transmit data bus
	output logic [4:0] phy_addr, // Mux-poll address
	input wire logic [3:0] direct_poll_tx_cell_avail, // Direct avail lines
	output logic [1:0] direct_sel, // Direct PHY in use
	input wire logic [7:0] src_data, // Source byte
	input wire logic src_valid, // Source byte valid
	output logic src_ready, // Source byte taken
	input wire logic force_err, // Force MII error
	input wire logic tx_req, // HDLC wants to send
	output logic tx_granted, // HDLC grant seen
	output logic [3:0] hdlc_out, // HDLC data lanes
	output logic [7:0] rx_byte, // Slave byte taken
	output logic rx_byte_valid, // Slave byte strobe
	output logic mii_col, // Collision seen
	output logic mii_crs // Carrier seen
);
	localparam int AW = $clog2(DEPTH);
	// One whole cell must fit; pointers only wrap at a power of two
	if (CELLS != CELL_BYTES || DEPTH < CELLS || DEPTH != (1 << AW))
	begin : g_bad_cfg
		$error("upt_port: unsupported cell size or depth");
	end
	// ------------------------------------------------------------
	// Mode decode helpers
	// ------------------------------------------------------------
	function automatic logic is_master(input upt_mode_t m);
		return (m == MODE_UTOPIA_DIRECT) || (m == MODE_UTOPIA_MUX);
	endfunction : is_master
	function automatic logic is_hdlc(input upt_mode_t m);
		return (m == MODE_HDLC_SERIAL) || (m == MODE_HDLC_NIBBLE);
	endfunction : is_hdlc
	typedef enum logic [1:0] {ST_POLL, ST_SEND} upt_state_t;
	// ------------------------------------------------------------
	// Master transmit state
	// ------------------------------------------------------------
	upt_state_t state_q, state_d;
	logic [5:0] cnt_q, cnt_d;
	logic [4:0] addr_q, addr_d;
	logic [1:0] dsel_q, dsel_d;
	logic [7:0] txd_q, txd_d;
	logic enb_n_q, enb_n_d, soc_q, soc_d, take_q, take_d, idle_q, idle_d;
	logic clav_in;
	// Avail seen by master depends on polling style
	always_comb
	begin
		clav_in = pin_i[PIN_CLAV];
		if (mode == MODE_UTOPIA_DIRECT)
			clav_in = direct_poll_tx_cell_avail[dsel_q];
	end

	// Poll, then stream one cell; idle cell when source is empty
	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		dsel_d = dsel_q;
		txd_d = txd_q;
		enb_n_d = 1'b1;
		soc_d = 1'b0;
		take_d = 1'b0;
		idle_d = idle_q;
		case (state_q)
			ST_POLL:
			begin
				if (is_master(mode) && clav_in && addr_q != NULL_PORT)
				begin
					state_d = ST_SEND;
					cnt_d = 6'h00;
					idle_d = !src_valid;
				end
				else if (mode == MODE_UTOPIA_MUX)
					// Skip 31 so the null port never gets a real cell
					addr_d = (addr_q >= MAX_PHY_ADDR) ? 5'h00 : addr_q + 5'h01;
				else
					dsel_d = dsel_q + 2'h1;
			end
			ST_SEND:
			begin
				enb_n_d = 1'b0;
				soc_d = (cnt_q == 6'h00);
				txd_d = idle_q ? IDLE_BYTE : src_data;
				take_d = !idle_q;
				cnt_d = cnt_q + 6'h01;
				if (cnt_q == 6'(CELLS - 1))
					state_d = ST_POLL;
			end
			default: state_d = ST_POLL;
		endcase
		if (!is_master(mode))
			state_d = ST_POLL;
	end
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_q <= ST_POLL;
			cnt_q <= 6'h00;
			addr_q <= 5'h00;
			dsel_q <= 2'h0;
			txd_q <= 8'h00;
			enb_n_q <= 1'b1;
			soc_q <= 1'b0;
			take_q <= 1'b0;
			idle_q <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			dsel_q <= dsel_d;
			txd_q <= txd_d;
			enb_n_q <= enb_n_d;
			soc_q <= soc_d;
			take_q <= take_d;
			idle_q <= idle_d;
		end
	end

	// ------------------------------------------------------------
	// Slave receive side: buffer with whole-cell space test
	// ------------------------------------------------------------
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] used_q, used_d;
	logic slv_clav_q, slv_clav_d, rvalid_q, rvalid_d, wr, rd_move;
	logic [7:0] mem_q;
	// Bytes enter only when the far master enables, low active; they leave whenever the buffer holds any
	always_comb
	begin
		wr = (mode == MODE_UTOPIA_SLAVE) && !pin_i[PIN_TXEN];
		wp_d = wr ? wp_q + 1'b1 : wp_q;
		rd_move = used_q != '0;
		rp_d = rd_move ? rp_q + 1'b1 : rp_q;
		used_d = used_q + (AW+1)'(wr) - (AW+1)'(rd_move);
		// Room for a full cell past anything in flight
		slv_clav_d = (mode == MODE_UTOPIA_SLAVE) &&
			(used_d <= (AW+1)'(DEPTH - CELLS));
		rvalid_d = rd_move;
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			wp_q <= '0;
			rp_q <= '0;
			used_q <= '0;
			slv_clav_q <= 1'b0;
			rvalid_q <= 1'b0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			used_q <= used_d;
			slv_clav_q <= slv_clav_d;
			rvalid_q <= rvalid_d;
		end
	end

	upt_mem #(.WIDTH(8), .DEPTH(DEPTH)) u_mem (
		.ref_clk(ref_clk),
		.wr_en(wr),
		.wr_addr(wp_q),
		.wr_data(src_data), // Slave bytes share the source bus
		.rd_addr(rp_q),
		.rd_data(mem_q)
	);
	// ------------------------------------------------------------
	// MII, HDLC and pin drive
	// ------------------------------------------------------------
	upt_pins_t pins_d;
	logic rts_n_q, rts_n_d, grant_q, grant_d, col_d, crs_d;
	logic [3:0] hd_q, hd_d;
	// Pin direction follows personality; oe low means driven
	always_comb
	begin
		pins_d.o = 3'b111;
		pins_d.oe_n = 3'b111;
		// RTS is free of data edges: it tracks the request only
		rts_n_d = !(is_hdlc(mode) && tx_req);
		grant_d = !rts_n_q && !pin_i[PIN_TXEN] && is_hdlc(mode);
		hd_d = (mode == MODE_HDLC_NIBBLE) ? src_data[3:0] :
			{3'b000, src_data[0]};
		col_d = (mode == MODE_MII) && pin_i[PIN_TXEN];
		crs_d = (mode == MODE_MII) && pin_i[PIN_CLAV];
		case (mode)
			MODE_UTOPIA_DIRECT, MODE_UTOPIA_MUX:
			begin
				pins_d.o[PIN_TXEN] = enb_n_d;
				pins_d.o[PIN_SOC] = soc_d;
				pins_d.oe_n = 3'b010;
			end
			MODE_UTOPIA_SLAVE:
			begin
				pins_d.o[PIN_CLAV] = slv_clav_d;
				pins_d.oe_n = 3'b101;
			end
			MODE_MII:
			begin
				pins_d.o[PIN_SOC] = force_err;
				pins_d.oe_n = 3'b011;
			end
			MODE_HDLC_SERIAL, MODE_HDLC_NIBBLE:
			begin
				pins_d.o[PIN_CLAV] = rts_n_d;
				pins_d.oe_n = 3'b101;
			end
			default: pins_d.oe_n = 3'b111;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pins <= '{o: 3'b111, oe_n: 3'b111};
			rts_n_q <= 1'b1;
			grant_q <= 1'b0;
			hd_q <= 4'h0;
			mii_col <= 1'b0;
			mii_crs <= 1'b0;
		end
		else
		begin
			pins <= pins_d;
			rts_n_q <= rts_n_d;
			grant_q <= grant_d;
			hd_q <= hd_d;
			mii_col <= col_d;
			mii_crs <= crs_d;
		end
	end

	// Output registers
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			txd <= 8'h00;
			phy_addr <= 5'h00;
			direct_sel <= 2'h0;
			src_ready <= 1'b0;
			rx_byte_valid <= 1'b0;
			rx_byte <= 8'h00;
			tx_granted <= 1'b0;
			hdlc_out <= 4'h0;
		end
		else
		begin
			txd <= txd_d;
			phy_addr <= addr_d;
			direct_sel <= dsel_d;
			src_ready <= take_d;
			rx_byte_valid <= rvalid_q;
			rx_byte <= mem_q;
			tx_granted <= grant_q;
			hdlc_out <= hd_q;
		end
	end
endmodule : upt_port
`default_nettype wire

// ---- test/test_upt_port.sv ----
// Purpose: self-checking bench for the upper port A pins
// Assumes: mode changes only under reset
// Notes: random data from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((e) !== (g)) begin \
	failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_upt_port
	import upt_pkg::*;
;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	upt_mode_t mode = MODE_UTOPIA_DIRECT;
	upt_pins_t pins;
	logic [2:0] pin_i;
	logic [7:0] txd, rx_byte;
	logic [7:0] src_data = 8'h00;
	logic [4:0] phy_addr;
	logic [3:0] avail, hdlc_out;
	logic [1:0] direct_sel;
	logic src_valid = 1'b0, force_err = 1'b0, tx_req = 1'b0;
	logic slow = 1'b0, col = 1'b0, crs = 1'b0, send = 1'b0;
	logic src_ready, tx_granted, rx_byte_valid, mii_col, mii_crs;
	int cells, last_len, failures = 0, cmp_count = 0, cyc = 0;
	logic [7:0] sent[$];
	logic [7:0] got[$];
	upt_port #(.CELLS(CELL_BYTES), .DEPTH(FIFO_DEPTH)) dut (
		.ref_clk(ref_clk), .reset(reset), .mode(mode), .pin_i(pin_i),
		.pins(pins), .txd(txd), .phy_addr(phy_addr),
		.direct_poll_tx_cell_avail(avail), .direct_sel(direct_sel),
		.src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
		.force_err(force_err), .tx_req(tx_req), .tx_granted(tx_granted),
		.hdlc_out(hdlc_out), .rx_byte(rx_byte),
		.rx_byte_valid(rx_byte_valid), .mii_col(mii_col), .mii_crs(mii_crs)
	);
	upt_phy_model phy (
		.ref_clk(ref_clk), .mode(mode), .pins(pins), .slow(slow), .col(col),
		.crs(crs), .send(send), .pin_i(pin_i), .avail_lines(avail),
		.cells(cells), .last_len(last_len)
	);
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Cycle ceiling cuts a hang short
	always @(posedge ref_clk)
	begin
		cyc++;
		if (rx_byte_valid && !reset)
			got.push_back(rx_byte);
		if (cyc == 4000)
		begin
			failures++;
			close_out();
		end
	end
	task close_out;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	// Serial mode uses lane zero only; nibble mode all four
	function automatic logic [3:0] lanes_exp(input int nib, input logic [7:0] b);
		return nib ? b[3:0] : {3'b000, b[0]};
	endfunction : lanes_exp
	task automatic set_mode(upt_mode_t m);
		reset = 1'b1;
		mode = m;
		repeat (10) @(negedge ref_clk);
		reset = 1'b0;
	endtask : set_mode
	// Idle and real cells alternate; the PHY stalls at random
	task automatic run_master(upt_mode_t m);
		int n0;
		set_mode(m);
		for (int c = 0; c < 4; c++)
		begin
			src_valid = c[0];
			slow = 1'($urandom);
			n0 = cells;
			while (cells == n0)
			begin
				@(negedge ref_clk);
				if (!pins.o[0] && c[0] && src_ready)
				begin
					`CHK("txd", src_data, txd)
					src_data = 8'($urandom);
				end
				if (!pins.o[0] && !c[0])
					`CHK("idle", IDLE_BYTE, txd)
				if (!pins.o[0])
					`CHK("ready", c[0], src_ready)
				if (m == MODE_UTOPIA_MUX)
					`CHK("addr", 1'b1, phy_addr <= MAX_PHY_ADDR)
			end
			`CHK("cell len", CELL_BYTES, last_len)
		end
		src_valid = 1'b0;
	endtask : run_master
	initial
	begin
		void'($urandom(32'hb1142c1b));
		run_master(MODE_UTOPIA_DIRECT);
		run_master(MODE_UTOPIA_MUX);
		set_mode(MODE_MII);
		repeat (40)
		begin
			{force_err, col, crs} = 3'($urandom);
			@(negedge ref_clk);
			`CHK("tx err", force_err, pins.o[2])
			`CHK("col", col, mii_col)
			`CHK("crs", crs, mii_crs)
		end
		force_err = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			set_mode(i ? MODE_HDLC_NIBBLE : MODE_HDLC_SERIAL);
			src_data = 8'($urandom);
			tx_req = 1'b1;
			for (int w = 0; w < 10 && tx_granted !== 1'b1; w++)
				@(negedge ref_clk);
			`CHK("grant", 1'b1, tx_granted)
			`CHK("rts", 1'b0, pins.o[1])
			`CHK("lanes", lanes_exp(i, src_data), hdlc_out)
			tx_req = 1'b0;
		end
		set_mode(MODE_UTOPIA_SLAVE);
		// Let one edge pass so the pins leave their reset value
		@(negedge ref_clk);
		`CHK("room", 1'b1, pins.o[1])
		`CHK("room drive", 1'b0, pins.oe_n[1])
		got.delete();
		repeat (CELL_BYTES)
		begin
			send = 1'b1;
			src_data = 8'($urandom);
			sent.push_back(src_data);
			@(negedge ref_clk);
		end
		send = 1'b0;
		repeat (80) @(negedge ref_clk);
		`CHK("rx count", CELL_BYTES, got.size())
		foreach (sent[k])
			`CHK("rx byte", sent[k], got[k])
		close_out();
	end
endmodule : test_upt_port
`default_nettype wire

// ---- test/upt_phy_model.sv ----
// Purpose: far-side PHY, modem or master for the port
// Assumes: pin_i resolves device drive over model drive
// Notes: released lines toggle each cycle unless the mode gives them a model level
`timescale 1ns/1ps
`default_nettype none
module upt_phy_model
	import upt_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire upt_mode_t mode, // Personality
	input wire upt_pins_t pins, // Device drive
	input wire logic slow, // Hold off after a cell
	input wire logic col, // Collision to report
	input wire logic crs, // Carrier to report
	input wire logic send, // Far master sending
	output logic [2:0] pin_i, // Wire levels
	output logic [3:0] avail_lines, // Direct avail
	output int cells, // Cells taken
	output int last_len // Bytes in last cell
);
	// ----------------------------------------
	// Cell sink and line levels
	// ----------------------------------------
	int cnt = 0;
	int gap = 0;
	logic clear_q = 1'b1;
	logic tog_q = 1'b0;
	logic room;
	initial cells = 0;
	initial last_len = 0;
	// Count each cell, then maybe stall before taking another
	always @(posedge ref_clk)
	begin
		tog_q <= !tog_q;
		clear_q <= pins.o[1];
		if (!pins.o[0] && !pins.oe_n[0])
			cnt <= cnt + 1;
		else if (cnt != 0)
		begin
			last_len <= cnt;
			cells <= cells + 1;
			cnt <= 0;
			gap <= slow ? 7 : 0;
		end
		else if (gap != 0)
			gap <= gap - 1;
	end
	assign room = gap == 0 && cnt == 0;
	// Device drive wins wherever its enable is low
	always_comb
	begin
		pin_i = {tog_q, !tog_q, tog_q};
		case (mode)
			MODE_UTOPIA_MUX: pin_i[1] = room;
			MODE_MII: pin_i[1:0] = {crs, col};
			MODE_HDLC_SERIAL, MODE_HDLC_NIBBLE: pin_i[0] = clear_q;
			MODE_UTOPIA_SLAVE: pin_i[0] = !send;
			default: ;
		endcase
		for (int b = 0; b < 3; b++)
			if (!pins.oe_n[b])
				pin_i[b] = pins.o[b];
		// PHYs zero and two take cells; no line shows room it lacks
		avail_lines = room ? 4'h5 : 4'h0;
	end
endmodule : upt_phy_model
`default_nettype wire

// ---- test/upt_port_properties.sv ----
// Purpose: temporal checks on the upper port A pins
// Assumes: mode only changes under reset
// Notes: bound onto every upt_port
`timescale 1ns/1ps
`default_nettype none
module upt_port_props
	import upt_pkg::*;
#(
	parameter int CELLS = CELL_BYTES,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk, // Clock
	input wire logic reset, // Sync reset
	input wire upt_mode_t mode, // Personality
	input wire logic [2:0] pin_i, // Pin levels
	input wire upt_pins_t pins, // Pin drive
	input wire logic [4:0] phy_addr, // Mux address
	input wire logic [3:0] direct_poll_tx_cell_avail, // Avail lines
	input wire logic [1:0] direct_sel, // Direct PHY
	input wire logic force_err, // Error request
	input wire logic tx_req, // HDLC request
	input wire logic tx_granted, // HDLC grant
	input wire logic mii_col // Collision copy
);
	// ----------------------------------------
	// Helpers and properties
	// ----------------------------------------
	logic master, hdlc, drv1, room;
	logic [6:0] run_q, run_d;
	assign master = mode inside {MODE_UTOPIA_DIRECT, MODE_UTOPIA_MUX};
	assign hdlc = mode inside {MODE_HDLC_SERIAL, MODE_HDLC_NIBBLE};
	assign drv1 = hdlc || mode == MODE_UTOPIA_SLAVE;
	// Room as the master saw it, per polling style
	assign room = (mode == MODE_UTOPIA_MUX) ? pin_i[1]
		: direct_poll_tx_cell_avail[direct_sel];
	// Length of the enable-low run; a counter, too long to unroll
	always_comb
	begin
		run_d = (master && !pins.o[0]) ? run_q + 7'h01 : 7'h00;
	end
	always_ff @(posedge ref_clk)
	begin
		run_q <= reset ? 7'h00 : run_d;
	end
	default clocking ck @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_null_port_skip: assert property (mode == MODE_UTOPIA_MUX |-> phy_addr != NULL_PORT)
		else $error("null port selected");
	// Enable falls two sampled edges after the poll that chose the PHY
	a_start_on_room: assert property (master && $fell(pins.o[0]) |-> $past(room, 2))
		else $error("cell started without room");
	a_cell_length: assert property (master && $rose(pins.o[0]) |-> run_q == 7'(CELLS))
		else $error("enable run not one cell");
	a_soc_first: assert property (master && !$past(reset) |-> pins.o[2] == (!pins.o[0] && $past(pins.o[0])))
		else $error("start of cell misplaced");
	a_mii_err: assert property (mode == MODE_MII && !$past(reset) |-> pins.o[2] == $past(force_err))
		else $error("tx error not following request");
	a_mii_col: assert property (mode == MODE_MII && !$past(reset) |-> mii_col == $past(pin_i[0]))
		else $error("collision copy wrong");
	a_rts_request: assert property (hdlc && $past(tx_req) && !$past(reset) |-> !pins.o[1])
		else $error("request not driven low");
	a_grant_clear: assert property (hdlc && $rose(tx_granted) |-> $past(pin_i[0], 2) == 1'b0)
		else $error("grant without clear");
	a_pin_roles: assert property (!$past(reset) |-> pins.oe_n[1:0] == {!drv1, !master})
		else $error("pin direction wrong");
endmodule : upt_port_props
bind upt_port upt_port_props #(.CELLS(CELLS), .DEPTH(DEPTH)) u_props (
	.ref_clk(ref_clk), .reset(reset), .mode(mode), .pin_i(pin_i),
	.pins(pins), .phy_addr(phy_addr),
	.direct_poll_tx_cell_avail(direct_poll_tx_cell_avail),
	.direct_sel(direct_sel), .force_err(force_err), .tx_req(tx_req),
	.tx_granted(tx_granted), .mii_col(mii_col)
);
`default_nettype wire
